// >>> rtl/hpd_regs.svh
// Purpose: offsets, field positions and reset values of the port-off and
//          current budget registers
// Assumes: byte-wide configuration port, 8-bit register index
// Notes: definitions only
`ifndef HPD_REGS_SVH
`define HPD_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define HPD_OFS_SP_PORT_OFF 8'h0A
`define HPD_OFS_BP_PORT_OFF 8'h0B
`define HPD_OFS_SP_BUDGET 8'h0C
`define HPD_OFS_BP_BUDGET 8'h0D
`define HPD_OFS_REMAP 8'h08

// ****************************************
// field layout
// ****************************************
`define HPD_PORT_LSB 1
`define HPD_PORT_MSB 4
`define HPD_PORT_MASK 8'h1E
`define HPD_REMAP_BIT 3
`define HPD_NUM_PORTS 4

// ****************************************
// reset values
// ****************************************
`define HPD_RST_PORT_OFF 8'h00
`define HPD_RST_BUDGET 8'h32
`define HPD_RST_REMAP 8'h00

`endif

// >>> rtl/hpd_pkg.sv
// Purpose: types shared by the port-off and current budget block
// Assumes: four downstream ports
// Notes: none
package hpd_pkg;
  typedef logic [3:0] hpd_ports_t;
  typedef logic [7:0] hpd_byte_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpd_cfg_req_t;

  typedef struct packed {
    logic [2:0] count;
    logic [3:0] phys_of_log1;
    logic [3:0] phys_of_log2;
    logic [3:0] phys_of_log3;
    logic [3:0] phys_of_log4;
  } hpd_map_t;

  typedef enum logic [1:0] {
    HPD_CFG_STRAP = 2'b01,
    HPD_CFG_LOADED = 2'b10
  } hpd_cfg_src_t;
endpackage

// >>> rtl/hpd_port_map.sv
// Purpose: count of enabled ports and logical-to-physical renumbering
// Assumes: bit n of the off mask is physical port n+1
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hpd_port_map (
  input wire hpd_pkg::hpd_ports_t i_off,
  output hpd_pkg::hpd_map_t o_map
);
  import hpd_pkg::*;

  // ****************************************
  // packing of active ports
  // ****************************************
  always_comb begin
    logic [2:0] n;
    logic [3:0] slot [0:3];
    n = 3'h0;
    for (int k = 0; k < 4; k++) begin
      slot[k] = 4'h0;
    end
    for (int p = 0; p < 4; p++) begin
      if (!i_off[p]) begin
        slot[n[1:0]] = 4'(1 << p);
        n = 3'(n + 3'h1);
      end
    end
    o_map.count = n;
    o_map.phys_of_log1 = slot[0];
    o_map.phys_of_log2 = slot[1];
    o_map.phys_of_log3 = slot[2];
    o_map.phys_of_log4 = slot[3];
  end
endmodule
`default_nettype wire

// >>> rtl/hpd_port_cfg.sv
// Purpose: port-off masks and upstream current budgets of a 4-port hub
// Assumes: byte-wide configuration writes from the loader or serial slave
// Notes: registers are 8 bits, reached at their own index
//
// Operation
// - Self-powered mask bits 4..1 switch off ports 4..1 when one.
// - Bus-powered mask has the same layout and is used when bus powered.
// - Bits 7..5 and bit 0 of both masks are reserved and read zero.
// - In standard mode ports flagged in the active mask are off for good.
// - The port count reported equals the number of ports left on.
// - The remaining ports are renumbered as a consecutive set.
// - With the internal default set, the two strap pins pick off ports.
// - Self-powered budget is eight bits in 2 mA steps, reported as is.
// - Bus-powered budget is eight bits in 2 mA steps, reported as is.
// - Re-map select zero is standard mode, one is re-map mode.
`timescale 1ns/1ps
`default_nettype none
`include "hpd_regs.svh"
module hpd_port_cfg (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire hpd_pkg::hpd_cfg_req_t i_cfg,
  input wire logic i_use_default,
  input wire logic [1:0] i_port_off_strap_pins,
  input wire logic i_self_powered,
  output logic [7:0] o_rdata,
  output logic [2:0] o_port_count,
  output hpd_pkg::hpd_ports_t o_port_enabled,
  output hpd_pkg::hpd_map_t o_port_map,
  output logic [7:0] o_current_budget,
  output logic o_remap_mode
);
  import hpd_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic dflt_s1;
    logic dflt_s2;
    logic pwr_s1;
    logic pwr_s2;
    hpd_byte_t sp_off;
    hpd_byte_t bp_off;
    hpd_byte_t sp_budget;
    hpd_byte_t bp_budget;
    hpd_byte_t remap;
    hpd_byte_t rdata;
    hpd_ports_t enabled;
    logic [2:0] count;
    hpd_map_t map;
    hpd_byte_t budget;
  } hpd_state_t;

  hpd_state_t st_reg;
  hpd_state_t st_next;
  hpd_ports_t strap_off;
  hpd_ports_t active_off;
  hpd_map_t map_w;
  logic remap_on;

  // ****************************************
  // strap decode
  // ****************************************
  // straps: 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3 off
  always_comb begin
    unique case (st_reg.strap_s2)
      2'b00: strap_off = 4'h0;
      2'b01: strap_off = 4'h1;
      2'b10: strap_off = 4'h3;
      2'b11: strap_off = 4'h7;
    endcase
  end

  assign remap_on = st_reg.remap[`HPD_REMAP_BIT];

  // ****************************************
  // mask selection
  // ****************************************
  always_comb begin
    if (remap_on) begin
      active_off = 4'h0;
    end else if (st_reg.dflt_s2) begin
      active_off = strap_off;
    end else if (st_reg.pwr_s2) begin
      active_off = st_reg.sp_off[`HPD_PORT_MSB:`HPD_PORT_LSB];
    end else begin
      active_off = st_reg.bp_off[`HPD_PORT_MSB:`HPD_PORT_LSB];
    end
  end

  hpd_port_map hpd_port_map_inst (
    .i_off(active_off),
    .o_map(map_w)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.strap_s1 = i_port_off_strap_pins;
    st_next.strap_s2 = st_reg.strap_s1;
    st_next.dflt_s1 = i_use_default;
    st_next.dflt_s2 = st_reg.dflt_s1;
    st_next.pwr_s1 = i_self_powered;
    st_next.pwr_s2 = st_reg.pwr_s1;
    if (i_cfg.wr) begin
      unique case (i_cfg.addr)
        `HPD_OFS_SP_PORT_OFF:
          st_next.sp_off = i_cfg.wdata & `HPD_PORT_MASK;
        `HPD_OFS_BP_PORT_OFF:
          st_next.bp_off = i_cfg.wdata & `HPD_PORT_MASK;
        `HPD_OFS_SP_BUDGET: st_next.sp_budget = i_cfg.wdata;
        `HPD_OFS_BP_BUDGET: st_next.bp_budget = i_cfg.wdata;
        `HPD_OFS_REMAP:
          st_next.remap = i_cfg.wdata & 8'h08;
        default: ;
      endcase
    end
    st_next.rdata = 8'h00;
    if (i_cfg.rd) begin
      unique case (i_cfg.addr)
        `HPD_OFS_SP_PORT_OFF: st_next.rdata = st_reg.sp_off;
        `HPD_OFS_BP_PORT_OFF: st_next.rdata = st_reg.bp_off;
        `HPD_OFS_SP_BUDGET: st_next.rdata = st_reg.sp_budget;
        `HPD_OFS_BP_BUDGET: st_next.rdata = st_reg.bp_budget;
        `HPD_OFS_REMAP: st_next.rdata = st_reg.remap;
        default: st_next.rdata = 8'h00;
      endcase
    end
    st_next.enabled = ~active_off;
    st_next.count = map_w.count;
    st_next.map = map_w;
    st_next.budget = st_reg.pwr_s2 ? st_reg.sp_budget
                                   : st_reg.bp_budget;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.sp_off <= `HPD_RST_PORT_OFF;
      st_reg.bp_off <= `HPD_RST_PORT_OFF;
      st_reg.sp_budget <= `HPD_RST_BUDGET;
      st_reg.bp_budget <= `HPD_RST_BUDGET;
      st_reg.remap <= `HPD_RST_REMAP;
      st_reg.enabled <= 4'hF;
      st_reg.count <= 3'h4;
      st_reg.map <= {3'h4, 4'h1, 4'h2, 4'h4, 4'h8};
      st_reg.budget <= `HPD_RST_BUDGET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_port_count = st_reg.count;
  assign o_port_enabled = st_reg.enabled;
  assign o_port_map = st_reg.map;
  assign o_current_budget = st_reg.budget;
  assign o_remap_mode = remap_on;

  // ****************************************
  // checks
  // ****************************************
  sequence sp_off_write_s;
    i_cfg.wr && i_cfg.addr == `HPD_OFS_SP_PORT_OFF;
  endsequence

  sequence bp_off_write_s;
    i_cfg.wr && i_cfg.addr == `HPD_OFS_BP_PORT_OFF;
  endsequence

  sequence sp_budget_write_s;
    i_cfg.wr && i_cfg.addr == `HPD_OFS_SP_BUDGET;
  endsequence

  sequence bp_budget_write_s;
    i_cfg.wr && i_cfg.addr == `HPD_OFS_BP_BUDGET;
  endsequence

  sequence remap_write_s;
    i_cfg.wr && i_cfg.addr == `HPD_OFS_REMAP;
  endsequence

  // standard mode, mask of the present power mode in use
  sequence std_self_s;
    !remap_on && !st_reg.dflt_s2 && st_reg.pwr_s2;
  endsequence

  sequence std_bus_s;
    !remap_on && !st_reg.dflt_s2 && !st_reg.pwr_s2;
  endsequence

  // power mode held over two edges, budget path settled
  sequence self_held_s;
    st_reg.pwr_s2 ##1 st_reg.pwr_s2;
  endsequence

  sequence bus_held_s;
    !st_reg.pwr_s2 ##1 !st_reg.pwr_s2;
  endsequence

  sequence strap_mode_s;
    st_reg.dflt_s2 && !remap_on;
  endsequence

  reserved_bits_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st_reg.sp_off[0] == 1'b0) && (st_reg.sp_off[7:5] == 3'h0) &&
    (st_reg.bp_off[0] == 1'b0) && (st_reg.bp_off[7:5] == 3'h0))
    else $error("reserved mask bit set");

  reserved_read_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg.rd && (i_cfg.addr == `HPD_OFS_SP_PORT_OFF ||
    i_cfg.addr == `HPD_OFS_BP_PORT_OFF)) |=>
    (o_rdata & ~`HPD_PORT_MASK) == 8'h00)
    else $error("reserved mask bit read back");

  sp_mask_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    sp_off_write_s |=>
    st_reg.sp_off == ($past(i_cfg.wdata) & `HPD_PORT_MASK))
    else $error("self-powered mask not stored");

  bp_mask_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    bp_off_write_s |=>
    st_reg.bp_off == ($past(i_cfg.wdata) & `HPD_PORT_MASK))
    else $error("bus-powered mask not stored");

  sp_budget_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    sp_budget_write_s |=> st_reg.sp_budget == $past(i_cfg.wdata))
    else $error("self-powered budget not stored");

  bp_budget_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    bp_budget_write_s |=> st_reg.bp_budget == $past(i_cfg.wdata))
    else $error("bus-powered budget not stored");

  remap_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remap_write_s |=> st_reg.remap == ($past(i_cfg.wdata) & 8'h08))
    else $error("re-map select not stored");

  read_mask_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg.rd && i_cfg.addr == `HPD_OFS_SP_PORT_OFF) |=>
    o_rdata == $past(st_reg.sp_off))
    else $error("self-powered mask read wrong");

  read_budget_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg.rd && i_cfg.addr == `HPD_OFS_BP_BUDGET) |=>
    o_rdata == $past(st_reg.bp_budget))
    else $error("bus-powered budget read wrong");

  off_port_held_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    std_self_s |=>
    ((o_port_enabled & $past(st_reg.sp_off[4:1])) == 4'h0))
    else $error("disabled port reported enabled");

  sp_enable_exact_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    std_self_s |=> o_port_enabled == ~$past(st_reg.sp_off[4:1]))
    else $error("self-powered mask not applied");

  bp_enable_exact_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    std_bus_s |=> o_port_enabled == ~$past(st_reg.bp_off[4:1]))
    else $error("bus-powered mask not applied");

  port_count_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_port_count == 3'($countones(o_port_enabled)))
    else $error("port count mismatch");

  first_logical_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (o_port_count != 3'h0) |->
    (o_port_map.phys_of_log1 & o_port_enabled) != 4'h0)
    else $error("logical port one not an active port");

  map_ascending_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (o_port_count >= 3'h2) |->
    (o_port_map.phys_of_log2 > o_port_map.phys_of_log1))
    else $error("logical ports not in ascending order");

  strap_select_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st_reg.dflt_s2 && !remap_on && st_reg.strap_s2 == 2'b11) |=>
    o_port_count == 3'h1)
    else $error("strap pins not applied");

  strap_count_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    strap_mode_s |=> o_port_count == 3'(4 - $past(st_reg.strap_s2)))
    else $error("strap port count wrong");

  budget_mode_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    self_held_s |-> o_current_budget == $past(st_reg.sp_budget))
    else $error("self-powered budget not reported");

  bus_budget_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    bus_held_s |-> o_current_budget == $past(st_reg.bp_budget))
    else $error("bus-powered budget not reported");

  remap_all_on_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    remap_on ##1 remap_on |-> o_port_enabled == 4'hF)
    else $error("mask applied in re-map mode");
endmodule
`default_nettype wire

// >>> test/hpd_cfg_master.sv
// Purpose: configuring party writing and reading config bytes
// Assumes: one-cycle wr/rd pulses launched at the falling edge
// Notes: keeps the self-powered budget at fifty or below
`timescale 1ns/1ps
`default_nettype none
module hpd_cfg_master (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output hpd_pkg::hpd_cfg_req_t o_cfg
);
  import hpd_pkg::*;
  initial o_cfg = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0C && d > 8'h32) d = 8'h32;
    @(negedge i_clk);
    o_cfg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    o_cfg = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge i_clk);
    o_cfg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    q = i_rdata;
    o_cfg = '0;
  endtask
endmodule
`default_nettype wire

// >>> test/hub_port_disable_power_config_tb.sv
// Purpose: self-checking bench of the port-off and budget registers
// Assumes: inputs change at the falling edge
// Notes: integer model compared after every settle
`timescale 1ns/1ps
`default_nettype none
module hub_port_disable_power_config_tb;
  import hpd_pkg::*;
  logic i_clk = 0, i_rst = 1, i_use_default = 0, i_self_powered = 1;
  logic [1:0] i_port_off_strap_pins = 2'h0;
  hpd_cfg_req_t cfg;
  hpd_ports_t en;
  hpd_map_t map;
  logic [7:0] rdata, budget, q;
  logic [2:0] cnt;
  logic remap;
  int fail_count = 0, n_checks = 0, seed = 77;
  int sp = 0, bp = 0, bs = 50, bb = 50, rm = 0, r1, r2;
  always #12.5 i_clk = ~i_clk;
  hpd_port_cfg hpd_port_cfg_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_cfg(cfg), .i_use_default(i_use_default),
    .i_port_off_strap_pins(i_port_off_strap_pins),
    .i_self_powered(i_self_powered), .o_rdata(rdata),
    .o_port_count(cnt), .o_port_enabled(en), .o_port_map(map),
    .o_current_budget(budget), .o_remap_mode(remap));
  hpd_cfg_master hpd_cfg_master_inst (.i_clk(i_clk), .i_rdata(rdata),
    .o_cfg(cfg));
  // ****************************************
  // compare and report
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t read %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_out(input logic [18:0] g, input logic [18:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t output %h exp %h", $time, g, e);
    end
  endtask
  // ****************************************
  // model of the port outputs and readback
  // ****************************************
  task automatic check_outs();
    int off;
    int act[$];
    logic [18:0] e;
    e = '0;
    if (rm != 0) off = 0;
    else if (i_use_default) off = (1 << i_port_off_strap_pins) - 1;
    else off = ((i_self_powered ? sp : bp) >> 1) & 15;
    for (int p = 0; p < 4; p++) begin
      if (!off[p]) act.push_back(p);
    end
    foreach (act[j]) e[(3 - j) * 4 +: 4] = 4'(1 << act[j]);
    e[18:16] = 3'(act.size());
    chk_out(map, e);
    chk_out(19'({remap, cnt, en}), 19'({rm[0], e[18:16], ~off[3:0]}));
    chk_out(19'(budget), 19'(i_self_powered ? bs : bb));
  endtask
  task automatic read_all();
    hpd_cfg_master_inst.rd(8'h08, q);
    chk_rd(q, 8'(rm << 3));
    hpd_cfg_master_inst.rd(8'h0A, q);
    chk_rd(q, 8'(sp));
    hpd_cfg_master_inst.rd(8'h0B, q);
    chk_rd(q, 8'(bp));
    hpd_cfg_master_inst.rd(8'h0C, q);
    chk_rd(q, 8'(bs));
    hpd_cfg_master_inst.rd(8'h0D, q);
    chk_rd(q, 8'(bb));
    hpd_cfg_master_inst.rd(8'h0E, q);
    chk_rd(q, 8'h00);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 0;
    repeat (4) @(negedge i_clk);
    check_outs();
    read_all();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      hpd_cfg_master_inst.wr(8'h0A, r1[7:0]);
      hpd_cfg_master_inst.wr(8'h0B, r1[15:8]);
      hpd_cfg_master_inst.wr(8'h0C, r2[7:0]);
      hpd_cfg_master_inst.wr(8'h0D, r1[23:16]);
      hpd_cfg_master_inst.wr(8'h08, {r1[31:28], r1[27] & r2[13], r1[26:24]});
      hpd_cfg_master_inst.wr(8'h0F, r2[7:0]);
      sp = r1[7:0] & 8'h1E;
      bp = r1[15:8] & 8'h1E;
      bs = (r2[7:0] > 8'h32) ? 50 : r2[7:0];
      bb = r1[23:16];
      rm = r1[27] & r2[13];
      i_self_powered = r2[8];
      i_use_default = r2[9] & r2[10];
      i_port_off_strap_pins = r2[12:11];
      repeat (4) @(negedge i_clk);
      check_outs();
      read_all();
      $display("test %0d done", i);
    end
    // reset in mid-run brings back the reset values
    i_rst = 1;
    repeat (2) @(negedge i_clk);
    i_rst = 0;
    sp = 0;
    bp = 0;
    bs = 50;
    bb = 50;
    rm = 0;
    repeat (4) @(negedge i_clk);
    check_outs();
    read_all();
    $display("test mid reset done");
    end_sim();
  end
endmodule
`default_nettype wire
